// ---- common/rrn_pkg.sv ----
// ****************************************
// package for the return/rotate/no-op execution block
// ****************************************
package rrn_pkg;

    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam logic [3:0] OP_RETLIT = 4'h8;
    localparam logic [5:0] OP_ROT_L = 6'h0D;
    localparam logic [5:0] OP_ROT_R = 6'h0C;
    localparam logic [11:0] OP_NOOP = 12'h000;
    localparam int unsigned CARRY_BIT = 0;
    localparam int unsigned DEST_BIT = 5;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [8:0] PC_RST = 9'h000;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [4:0] FADDR_RST = 5'h00;
    localparam logic [7:0] FDATA_RST = 8'h00;
    localparam logic [1:0] RET_CYCLES = 2'h2;

    typedef enum logic [2:0]
    {
        RRN_OTHER,
        RRN_NOOP,
        RRN_RETLIT,
        RRN_ROT_L,
        RRN_ROT_R
    } rrn_op_t;

    typedef struct packed
    {
        logic wr;
        logic [4:0] addr;
        logic [7:0] data;
    } rrn_fwr_t;

endpackage

// ---- rtl/rrn_exec.sv ----
`timescale 1ns/100ps
`default_nettype none
module rrn_exec
    import rrn_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    // instruction and operands
    input wire logic I_VALID,
    input wire logic [11:0] I_OPCODE,
    input wire logic [7:0] I_FILE_DATA,
    input wire logic [8:0] I_STACK_HEAD,
    // results
    output logic [7:0] O_ACC,
    output logic O_CARRY,
    output logic [8:0] O_PC,
    output logic O_FILE_WR,
    output logic [4:0] O_FILE_ADDR,
    output logic [7:0] O_FILE_DATA,
    output logic O_STACK_POP,
    output logic O_BUSY,
    output logic O_ILLEGAL
);

    // ****************************************
    // decode
    // ****************************************
    function automatic rrn_op_t decode(input logic [11:0] instr);
        rrn_op_t r;
        r = RRN_OTHER;
        if (instr == OP_NOOP)
            r = RRN_NOOP;
        else if (instr[11:8] == OP_RETLIT)
            r = RRN_RETLIT;
        else if (instr[11:6] == OP_ROT_L)
            r = RRN_ROT_L;
        else if (instr[11:6] == OP_ROT_R)
            r = RRN_ROT_R;
        return r;
    endfunction

    rrn_op_t op;
    assign op = decode(I_OPCODE);

    // ****************************************
    // execute
    // ****************************************
    logic [7:0] acc_q, acc_d;
    logic carry_q, carry_d;
    logic [8:0] pc_q, pc_d;
    rrn_fwr_t fwr_q, fwr_d;
    logic pop_q, pop_d;
    logic busy_q, busy_d;
    logic ill_q, ill_d;
    logic [7:0] rot;
    logic rot_c;

    always_comb
    begin
        acc_d = acc_q;
        carry_d = carry_q;
        pc_d = pc_q;
        fwr_d = '{wr: 1'b0, addr: fwr_q.addr, data: fwr_q.data};
        pop_d = 1'b0;
        busy_d = 1'b0;
        ill_d = 1'b0;
        rot = I_FILE_DATA;
        rot_c = carry_q;
        if (busy_q)
        begin
            pc_d = I_STACK_HEAD;
        end
        else if (I_VALID)
        begin
            unique case (op)
                RRN_NOOP:
                    pc_d = pc_q + 9'h001;
                RRN_RETLIT:
                begin
                    acc_d = I_OPCODE[7:0];
                    pop_d = 1'b1;
                    busy_d = 1'b1;
                end
                RRN_ROT_L, RRN_ROT_R:
                begin
                    if (op == RRN_ROT_L)
                    begin
                        rot = {I_FILE_DATA[6:0], carry_q};
                        rot_c = I_FILE_DATA[7];
                    end
                    else
                    begin
                        rot = {carry_q, I_FILE_DATA[7:1]};
                        rot_c = I_FILE_DATA[0];
                    end
                    carry_d = rot_c;
                    pc_d = pc_q + 9'h001;
                    if (I_OPCODE[DEST_BIT])
                        fwr_d = '{wr: 1'b1, addr: I_OPCODE[4:0],
                            data: rot};
                    else
                        acc_d = rot;
                end
                RRN_OTHER:
                begin
                    ill_d = 1'b1;
                    pc_d = pc_q + 9'h001;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            acc_q <= ACC_RST;
            carry_q <= CARRY_RST;
            pc_q <= PC_RST;
            fwr_q <= '{wr: 1'b0, addr: FADDR_RST, data: FDATA_RST};
            pop_q <= 1'b0;
            busy_q <= 1'b0;
            ill_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            carry_q <= carry_d;
            pc_q <= pc_d;
            fwr_q <= fwr_d;
            pop_q <= pop_d;
            busy_q <= busy_d;
            ill_q <= ill_d;
        end
    end

    assign O_ACC = acc_q;
    assign O_CARRY = carry_q;
    assign O_PC = pc_q;
    assign O_FILE_WR = fwr_q.wr;
    assign O_FILE_ADDR = fwr_q.addr;
    assign O_FILE_DATA = fwr_q.data;
    assign O_STACK_POP = pop_q;
    assign O_BUSY = busy_q;
    assign O_ILLEGAL = ill_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    ret_literal_a: assert property ((I_VALID && !busy_q && op == RRN_RETLIT)
        |=> acc_q == $past(I_OPCODE[7:0]))
        else $error("literal not loaded");
    ret_pc_a: assert property ((I_VALID && !busy_q && op == RRN_RETLIT)
        |=> busy_q ##1 (!busy_q && pc_q == $past(I_STACK_HEAD)))
        else $error("return address not loaded");
    ret_flags_a: assert property ((I_VALID && !busy_q && op == RRN_RETLIT)
        |=> $stable(carry_q) [*2])
        else $error("return changed carry");
    rot_left_a: assert property ((I_VALID && !busy_q && op == RRN_ROT_L)
        |=> carry_q == $past(I_FILE_DATA[7]))
        else $error("left rotate carry wrong");
    rot_right_a: assert property ((I_VALID && !busy_q && op == RRN_ROT_R
        && I_OPCODE[DEST_BIT])
        |=> fwr_q.data == {$past(carry_q), $past(I_FILE_DATA[7:1])})
        else $error("right rotate data wrong");
    rot_dest_a: assert property ((I_VALID && !busy_q && !I_OPCODE[DEST_BIT]
        && (op == RRN_ROT_L || op == RRN_ROT_R)) |=> !fwr_q.wr)
        else $error("accumulator rotate wrote file");
    noop_pc_a: assert property ((I_VALID && !busy_q && op == RRN_NOOP)
        |=> pc_q == $past(pc_q) + 9'h001 && $stable(acc_q)
        && $stable(carry_q) && !fwr_q.wr)
        else $error("no-operation changed state");
    ret_pop_a: assert property ((I_VALID && !busy_q && op == RRN_RETLIT)
        |=> pop_q ##1 !pop_q)
        else $error("stack pop not a single pulse");
    busy_ignore_a: assert property (busy_q |=> $stable(acc_q)
        && $stable(carry_q) && !fwr_q.wr && !ill_q && !busy_q)
        else $error("input taken during return");
    rot_left_data_a: assert property ((I_VALID && !busy_q
        && op == RRN_ROT_L && I_OPCODE[DEST_BIT])
        |=> fwr_q.data == {$past(I_FILE_DATA[6:0]), $past(carry_q)})
        else $error("left rotate data wrong");
    rot_right_carry_a: assert property ((I_VALID && !busy_q
        && op == RRN_ROT_R) |=> carry_q == $past(I_FILE_DATA[0])
        && pc_q == $past(pc_q) + 9'h001)
        else $error("right rotate carry or counter wrong");
    rot_file_a: assert property ((I_VALID && !busy_q && I_OPCODE[DEST_BIT]
        && (op == RRN_ROT_L || op == RRN_ROT_R))
        |=> fwr_q.wr && fwr_q.addr == $past(I_OPCODE[4:0])
        && $stable(acc_q))
        else $error("file rotate result misplaced");
    rot_acc_a: assert property ((I_VALID && !busy_q && op == RRN_ROT_R
        && !I_OPCODE[DEST_BIT])
        |=> acc_q == {$past(carry_q), $past(I_FILE_DATA[7:1])})
        else $error("accumulator rotate result wrong");
    noop_quiet_a: assert property ((I_VALID && !busy_q && op == RRN_NOOP)
        |=> !pop_q && !busy_q && !ill_q)
        else $error("no-operation raised a pulse");

    // ****************************************
    // coverage
    // ****************************************
    cov_ret_c: cover property (I_VALID && !busy_q && op == RRN_RETLIT);
    cov_rotl_c: cover property (I_VALID && !busy_q && op == RRN_ROT_L);
    cov_rotr_c: cover property (I_VALID && !busy_q && op == RRN_ROT_R);
    cov_noop_c: cover property (I_VALID && !busy_q && op == RRN_NOOP);
    cov_ret_twice_c: cover property ((I_VALID && !busy_q && op == RRN_RETLIT)
        ##2 (I_VALID && op == RRN_RETLIT));

endmodule
`default_nettype wire

// ---- testbench/rrn_exec_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module rrn_exec_tb
    import rrn_pkg::*;
;
    logic clk = 0, rst_n = 0, vld = 0, wr, pop, bsy, ill, c, e_c = CARRY_RST;
    logic [11:0] op = 12'h000;
    logic [7:0] fd = 8'h00, acc, fdo, e_acc = ACC_RST, e_data = FDATA_RST;
    logic [8:0] sh = 9'h000, pc, e_pc = PC_RST, shv;
    logic [4:0] fa, e_addr = FADDR_RST;
    logic e_wr = 0, e_pop = 0, e_busy = 0, e_ill = 0;
    logic [31:0] seed = 32'h37, s;
    int fails = 0, num_checks = 0;
    rrn_exec i_rrn_exec (.I_CLK(clk), .I_ARST_N(rst_n), .I_VALID(vld),
        .I_OPCODE(op), .I_FILE_DATA(fd), .I_STACK_HEAD(sh), .O_ACC(acc),
        .O_CARRY(c), .O_PC(pc), .O_FILE_WR(wr), .O_FILE_ADDR(fa),
        .O_FILE_DATA(fdo), .O_STACK_POP(pop), .O_BUSY(bsy), .O_ILLEGAL(ill));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [8:0] rot_exp(input logic l, input logic [7:0] f,
        input logic ci);
        return l ? {f, ci} : {f[0], ci, f[7:1]};
    endfunction
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // drive one instruction at a rising edge
    // ****************************************
    task automatic exec(input logic [11:0] o, input logic [7:0] f);
        logic [7:0] r;
        s = xs();
        shv = s[8:0];
        vld <= 1'b1;
        op <= o;
        fd <= f;
        sh <= shv;
        @(posedge clk);
        {e_wr, e_pop, e_busy, e_ill} = 4'h0;
        e_pc = e_pc + 9'(o[11:8] != OP_RETLIT);
        if (o[11:8] == OP_RETLIT)
        begin
            e_acc = o[7:0];
            {e_pop, e_busy} = 2'h3;
            op <= {OP_ROT_L, 1'b0, o[4:0]};
            @(posedge clk);
            {e_pop, e_busy} = 2'h0;
            e_pc = shv;
        end
        else if (o[11:6] == OP_ROT_L || o[11:6] == OP_ROT_R)
        begin
            {e_c, r} = rot_exp(o[6], f, e_c);
            if (o[DEST_BIT])
                {e_wr, e_addr, e_data} = {1'b1, o[4:0], r};
            else
                e_acc = r;
        end
        else if (o != OP_NOOP)
            e_ill = 1'b1;
    endtask
    always @(negedge clk)
    begin
        chk(acc === e_acc && c === e_c, "acc or carry");
        chk(pc === e_pc, "pc");
        chk({wr, pop, bsy, ill} === {e_wr, e_pop, e_busy, e_ill},
            "pulses");
        chk(fa === e_addr && fdo === e_data, "file write");
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        exec(12'h35F, 8'h80);
        exec(12'h300, 8'h01);
        exec(12'h8FF, 8'h00);
        exec(12'h800, 8'h00);
        exec(OP_NOOP, 8'h5A);
        exec(12'h341, 8'hA5);
        exec(12'h320, 8'hFE);
        $display("test corners done");
        repeat (400)
        begin
            s = xs();
            case (s[1:0])
                2'h0: exec(OP_NOOP, s[23:16]);
                2'h1: exec({OP_RETLIT, s[15:8]}, s[23:16]);
                2'h2: exec({5'h06, s[5:4], s[12:8]}, s[23:16]);
                default: exec({6'h0E, s[5:0]}, s[23:16]);
            endcase
        end
        vld <= 1'b0;
        @(posedge clk);
        {e_wr, e_pop, e_busy, e_ill} = 4'h0;
        @(posedge clk);
        $display("test random done");
        give_verdict();
    end
endmodule
`default_nettype wire
